// *** verilog/omp_regs.svh ***
// Constants for the operating mode and power controller.
`ifndef OMP_REGS_SVH
`define OMP_REGS_SVH
`define OMP_CKS_FAST_MIN 3'h2
`define OMP_SHIFT_BASE 4'h8
`define OMP_SHIFT_UNDIV 3'h0
`define OMP_DIV_CNT_W 6
`define OMP_DIV16_ALL 4'hf
`define OMP_DIV64_ALL 6'h3f
`define OMP_READY_TICKS 16
`define OMP_READY_W 5
`endif

// *** verilog/omp_pkg.sv ***
// Types shared by the operating mode and power controller.
package omp_pkg;
	// Gray codes along normal -> slow -> sleep -> idle_clock_stopped_mode -> idle_clock_running_mode.
	typedef enum logic [2:0]
	{
		OMP_NORMAL = 3'h0,
		OMP_SLOW = 3'h1,
		OMP_SLEEP = 3'h3,
		OMP_IDLE_CLOCK_STOPPED_MODE = 3'h2,
		OMP_IDLE_CLOCK_RUNNING_MODE = 3'h6
	} omp_mode_e;
endpackage

// *** verilog/omp_clk_if.sv ***
// Signals between the mode controller and its clock selector.
`timescale 1ns/10ps
interface omp_clk_if;
	logic fast_tick;
	logic slow_tick;
	logic fast_on;
	logic hi_lo;
	logic [2:0] div_code;
	logic sys_tick;
	logic using_fast;
	logic div16_tick;
	logic div64_tick;
	modport sel (input fast_tick, input slow_tick, input fast_on, input hi_lo, input div_code,
		output sys_tick, output using_fast, output div16_tick, output div64_tick);
	modport ctl (output fast_tick, output slow_tick, output fast_on, output hi_lo, output div_code,
		input sys_tick, input using_fast, input div16_tick, input div64_tick);
endinterface

// *** verilog/omp_clk_sel.sv ***
// Glitch-free system clock source and divider selector.
`timescale 1ns/10ps
`include "omp_regs.svh"
module omp_clk_sel
	import omp_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	omp_clk_if.sel bus
);
	logic [`OMP_DIV_CNT_W-1:0] div_cnt_reg;
	logic [`OMP_DIV_CNT_W-1:0] pre_cnt_reg;
	logic use_fast_reg;
	logic [2:0] shift_reg;

	////////////////////////////////////////////////////////////////////////////
	// Requested source and ratio; the ratio is 2 to the shift.
	wire want_fast = bus.hi_lo | (bus.div_code >= `OMP_CKS_FAST_MIN);
	wire [2:0] want_shift = bus.hi_lo ? `OMP_SHIFT_UNDIV : 3'(`OMP_SHIFT_BASE - {1'b0, bus.div_code});
	wire [`OMP_DIV_CNT_W-1:0] div_mask = `OMP_DIV_CNT_W'((7'h1 << shift_reg) - 7'h1);
	wire fast_end = bus.fast_tick & (div_cnt_reg == div_mask);
	wire cur_tick = use_fast_reg ? fast_end : bus.slow_tick;
	// A change is taken only at the end of a whole period, or when the fast
	// source is stopped and there is no period left to shorten.
	wire switch_ok = cur_tick | (use_fast_reg & ~bus.fast_on);

	assign bus.sys_tick = cur_tick;
	assign bus.using_fast = use_fast_reg;
	// The fixed internal taps stop with the fast oscillator since no ticks come.
	assign bus.div16_tick = bus.fast_tick & (pre_cnt_reg[3:0] == `OMP_DIV16_ALL);
	assign bus.div64_tick = bus.fast_tick & (pre_cnt_reg == `OMP_DIV64_ALL);

	////////////////////////////////////////////////////////////////////////////
	// Each period counts from zero; only a stop of the fast source lets a new ratio take over with the count left mid-period.
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			div_cnt_reg <= '0;
			pre_cnt_reg <= '0;
			use_fast_reg <= 1'b1;
			shift_reg <= `OMP_SHIFT_UNDIV;
		end
		else
		begin
			if (cur_tick)
				div_cnt_reg <= '0;
			else if (bus.fast_tick)
				div_cnt_reg <= div_cnt_reg + 1'b1;
			if (bus.fast_tick)
				pre_cnt_reg <= pre_cnt_reg + 1'b1;
			if (switch_ok)
			begin
				use_fast_reg <= want_fast;
				shift_reg <= want_shift;
			end
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	no_midswitch_a: assert property ((use_fast_reg != $past(use_fast_reg)) |-> $past(switch_ok))
		else $error("Clock source changed without a period boundary.");
	fast_period_a: assert property ((use_fast_reg && bus.fast_on && cur_tick) |=> (div_cnt_reg == '0))
		else $error("Fast system period did not restart from zero.");
endmodule

// *** verilog/omp_mode_ctrl.sv ***
// Operating mode and power mode controller, top level.
`timescale 1ns/10ps
`include "omp_regs.svh"
module omp_mode_ctrl
	import omp_pkg::*;
#(
	parameter int READY_TICKS = `OMP_READY_TICKS
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic hi_lo_clock_select_i,
	input wire logic [2:0] clock_divider_select_i,
	input wire logic idle_on_halt_enable_i,
	input wire logic keep_sysclk_in_idle_i,
	input wire logic halt_exec_i,
	input wire logic wake_i,
	input wire logic wdt_timeout_i,
	input wire logic wdt_clear_insn_i,
	input wire logic fast_osc_tick_i,
	input wire logic slow_osc_tick_i,
	output logic [2:0] mode_o,
	output logic fast_osc_enable_o,
	output logic fast_osc_ready_flag_o,
	output logic sys_clk_tick_o,
	output logic cpu_clk_tick_o,
	output logic time_base_tick_o,
	output logic slow_clk_tick_o,
	output logic fast_div16_tick_o,
	output logic fast_div64_tick_o,
	output logic cpu_hold_o,
	output logic state_retain_o,
	output logic watchdog_clear_o,
	output logic power_down_flag_o,
	output logic watchdog_timeout_flag_o
);
	initial
	begin
		if (READY_TICKS < 1 || READY_TICKS >= (1 << `OMP_READY_W))
			$error("READY_TICKS does not fit the ready counter.");
	end

	localparam logic [`OMP_READY_W-1:0] READY_LAST = `OMP_READY_W'(READY_TICKS);

	omp_mode_e state_reg;
	omp_mode_e state_next;
	logic fast_on_reg;
	logic [`OMP_READY_W-1:0] rdy_cnt_reg;
	logic ready_reg;
	logic sys_tick_reg;
	logic cpu_tick_reg;
	logic tb_tick_reg;
	logic slow_tick_reg;
	logic div16_reg;
	logic div64_reg;
	logic wdt_clr_reg;
	logic pdf_reg;
	logic to_reg;
	logic hold_reg;

	omp_clk_if clk_bus ();

	omp_clk_sel u_sel
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.bus(clk_bus)
	);

	////////////////////////////////////////////////////////////////////////////
	// Feed the selector and decode the run mode from the select bits.
	assign clk_bus.fast_tick = fast_osc_tick_i;
	assign clk_bus.slow_tick = slow_osc_tick_i;
	assign clk_bus.fast_on = fast_on_reg;
	assign clk_bus.hi_lo = hi_lo_clock_select_i;
	assign clk_bus.div_code = clock_divider_select_i;
	wire want_fast = hi_lo_clock_select_i | (clock_divider_select_i >= `OMP_CKS_FAST_MIN);
	wire run_mode = (state_reg == OMP_NORMAL) || (state_reg == OMP_SLOW);
	wire halt_mode = ~run_mode;
	wire halt_take = run_mode & halt_exec_i;
	omp_mode_e run_target;
	assign run_target = want_fast ? OMP_NORMAL : OMP_SLOW;
	omp_mode_e halt_target;
	assign halt_target = ~idle_on_halt_enable_i ? OMP_SLEEP :
		(keep_sysclk_in_idle_i ? OMP_IDLE_CLOCK_RUNNING_MODE : OMP_IDLE_CLOCK_STOPPED_MODE);

	////////////////////////////////////////////////////////////////////////////
	// Mode transitions: select bits steer run modes, halt enters low power.
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			OMP_NORMAL, OMP_SLOW:
				state_next = halt_exec_i ? halt_target : run_target;
			OMP_SLEEP, OMP_IDLE_CLOCK_STOPPED_MODE, OMP_IDLE_CLOCK_RUNNING_MODE:
				state_next = wake_i ? run_target : state_reg;
		endcase
	end

	// Fast oscillator runs in fast run, and in idle_clock_running_mode only when it is the source.
	wire fast_on_next = (state_next == OMP_NORMAL) || ((state_next == OMP_IDLE_CLOCK_RUNNING_MODE) && want_fast);
	wire ready_hit = fast_on_reg & fast_osc_tick_i & (rdy_cnt_reg == READY_LAST - 1'b1);
	// The CPU only clocks once the fast source is stable, so software that
	// polls the ready flag sees it high before the first fast instruction.
	wire cpu_tick_next = clk_bus.sys_tick & run_mode & (~clk_bus.using_fast | ready_reg);
	wire sys_tick_next = clk_bus.sys_tick & (run_mode | (state_reg == OMP_IDLE_CLOCK_RUNNING_MODE));
	wire tb_tick_next = slow_osc_tick_i & (state_reg != OMP_SLEEP);

	////////////////////////////////////////////////////////////////////////////
	// Mode state and oscillator enable.
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state_reg <= OMP_NORMAL;
			fast_on_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			fast_on_reg <= fast_on_next;
		end
	end

	// Ready counter restarts whenever the fast oscillator is stopped.
	always_ff @(posedge clock_i)
	begin
		if (rst_i || !fast_on_reg)
		begin
			rdy_cnt_reg <= '0;
			ready_reg <= 1'b0;
		end
		else if (fast_osc_tick_i && !ready_reg)
		begin
			rdy_cnt_reg <= rdy_cnt_reg + 1'b1;
			ready_reg <= ready_hit;
		end
	end

	// Registered clock enables; every output is a flip-flop.
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			sys_tick_reg <= 1'b0;
			cpu_tick_reg <= 1'b0;
			tb_tick_reg <= 1'b0;
			slow_tick_reg <= 1'b0;
			div16_reg <= 1'b0;
			div64_reg <= 1'b0;
		end
		else
		begin
			sys_tick_reg <= sys_tick_next;
			cpu_tick_reg <= cpu_tick_next;
			tb_tick_reg <= tb_tick_next;
			slow_tick_reg <= slow_osc_tick_i;
			div16_reg <= clk_bus.div16_tick;
			div64_reg <= clk_bus.div64_tick;
		end
	end

	// Halt level registered from the next state, so the hold output is a
	// plain flop yet still changes in the same cycle as the new mode code.
	// Decoding it from the mode register instead would put logic on a pin.
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			hold_reg <= 1'b0;
		else
			hold_reg <= (state_next != OMP_NORMAL) && (state_next != OMP_SLOW);
	end

	// Status flags; a hardware set wins over a same-cycle clear.
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			wdt_clr_reg <= 1'b0;
			pdf_reg <= 1'b0;
			to_reg <= 1'b0;
		end
		else
		begin
			wdt_clr_reg <= halt_take;
			pdf_reg <= halt_take | (pdf_reg & ~wdt_clear_insn_i);
			to_reg <= wdt_timeout_i | (to_reg & ~halt_take);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs. The retain level freezes memory, register and port writes.
	assign mode_o = state_reg;
	assign fast_osc_enable_o = fast_on_reg;
	assign fast_osc_ready_flag_o = ready_reg;
	assign sys_clk_tick_o = sys_tick_reg;
	assign cpu_clk_tick_o = cpu_tick_reg;
	assign time_base_tick_o = tb_tick_reg;
	assign slow_clk_tick_o = slow_tick_reg;
	assign fast_div16_tick_o = div16_reg;
	assign fast_div64_tick_o = div64_reg;
	assign cpu_hold_o = hold_reg;
	assign state_retain_o = hold_reg;
	assign watchdog_clear_o = wdt_clr_reg;
	assign power_down_flag_o = pdf_reg;
	assign watchdog_timeout_flag_o = to_reg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	sequence halt_seen_s;
		halt_take && !wdt_timeout_i;
	endsequence
	sequence halt_effect_s;
		watchdog_clear_o && power_down_flag_o && !watchdog_timeout_flag_o && cpu_hold_o;
	endsequence
	sequence wake_seen_s;
		halt_mode && wake_i;
	endsequence
	sequence run_entry_s;
		!cpu_hold_o && (mode_o == OMP_NORMAL || mode_o == OMP_SLOW);
	endsequence

	halt_entry_a: assert property (halt_seen_s |=> halt_effect_s)
		else $error("Halt did not clear watchdog and set power-down.");
	sleep_entry_a: assert property ((halt_take && !idle_on_halt_enable_i) |=> mode_o == OMP_SLEEP)
		else $error("Halt without idle enable missed sleep.");
	idle_kind_a: assert property ((halt_take && idle_on_halt_enable_i) |=>
		(mode_o == (keep_sysclk_in_idle_i ? OMP_IDLE_CLOCK_RUNNING_MODE : OMP_IDLE_CLOCK_STOPPED_MODE)))
		else $error("Halt entered the wrong idle mode.");
	ready_low_a: assert property ((state_reg == OMP_SLEEP || state_reg == OMP_IDLE_CLOCK_STOPPED_MODE) ##1
		(state_reg == OMP_SLEEP || state_reg == OMP_IDLE_CLOCK_STOPPED_MODE) |-> !fast_osc_ready_flag_o)
		else $error("Ready flag high while the fast oscillator is stopped.");
	ready_time_a: assert property ($rose(fast_osc_ready_flag_o) |-> rdy_cnt_reg == READY_LAST)
		else $error("Ready flag rose after the wrong tick count.");
	slow_fast_off_a: assert property ((state_reg == OMP_SLOW) [*2] |-> !fast_osc_enable_o)
		else $error("Fast oscillator running in slow mode.");
	cpu_halted_a: assert property (cpu_hold_o |=> !cpu_clk_tick_o)
		else $error("CPU clocked during a halt mode.");
	tb_sleep_a: assert property ((state_reg == OMP_SLEEP) [*2] |-> !time_base_tick_o)
		else $error("Time base ran in sleep.");
	tb_idle_clock_stopped_mode_a: assert property ((state_reg == OMP_IDLE_CLOCK_STOPPED_MODE && slow_osc_tick_i) |=> time_base_tick_o)
		else $error("Time base stopped in clock-stopped idle.");
	idle_clock_running_mode_sys_a: assert property ((state_reg == OMP_IDLE_CLOCK_RUNNING_MODE && clk_bus.sys_tick) |=> sys_clk_tick_o)
		else $error("System clock stopped in clock-running idle.");
	run_decode_a: assert property ((run_mode && !halt_exec_i) |=>
		(mode_o == ($past(want_fast) ? OMP_NORMAL : OMP_SLOW)))
		else $error("Run mode does not follow the select bits.");

	////////////////////////////////////////////////////////////////////////////
	// Flag, hold and wake checks. These guard the one-cycle pulses and the
	// levels that software reads, which a broken flop would silently stretch.
	wdt_clr_pulse_a: assert property (watchdog_clear_o |=> !watchdog_clear_o)
		else $error("Watchdog clear lasted more than one cycle.");
	hold_level_a: assert property (cpu_hold_o == !(mode_o == OMP_NORMAL || mode_o == OMP_SLOW))
		else $error("Hold level disagrees with the mode code.");
	pdf_clear_a: assert property ((wdt_clear_insn_i && !halt_take) |=> !power_down_flag_o)
		else $error("Power-down flag not cleared by the clear instruction.");
	timeout_set_a: assert property (wdt_timeout_i |=> watchdog_timeout_flag_o)
		else $error("Timeout flag not set by a watchdog timeout.");
	fast_off_halt_a: assert property ((state_reg == OMP_SLEEP || state_reg == OMP_IDLE_CLOCK_STOPPED_MODE) |->
		!fast_osc_enable_o)
		else $error("Fast oscillator running in sleep or clock-stopped idle.");
	wake_run_a: assert property (wake_seen_s |=> run_entry_s)
		else $error("Wake did not return to a run mode.");
	halt_stay_a: assert property ((halt_mode && !wake_i) |=> (mode_o == $past(mode_o)))
		else $error("Halt mode left without a wake.");
	slow_tick_a: assert property (slow_osc_tick_i |=> slow_clk_tick_o)
		else $error("Slow clock tick lost.");
	// Software may only trust the fast clock once the ready flag is up.
	cpu_ready_a: assert property ((run_mode && clk_bus.using_fast && !ready_reg) |=> !cpu_clk_tick_o)
		else $error("CPU clocked from an unsettled fast oscillator.");
endmodule

// *** verification/omp_osc_model.sv ***
// Behavioural model of the fast and slow RC oscillators that drive the controller's tick inputs.
`timescale 1ns/10ps
module omp_osc_model
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic fast_enable_i,
	output logic fast_tick_o = 1'b0,
	output logic slow_tick_o = 1'b0
);
	logic fast_phase_reg = 1'b0;
	logic [2:0] slow_cnt_reg = 3'h0;
	// A stopped fast oscillator gives no pulses at all, so a controller that uses it while off stalls.
	always @(posedge clock_i)
	begin
		fast_phase_reg <= rst_i ? 1'b0 : ~fast_phase_reg;
		fast_tick_o <= fast_enable_i & fast_phase_reg & ~rst_i;
	end
	// The slow oscillator cannot be disabled, so it ticks every eighth cycle even in reset.
	always @(posedge clock_i)
	begin
		slow_cnt_reg <= slow_cnt_reg + 3'h1;
		slow_tick_o <= (slow_cnt_reg == 3'h7);
	end
endmodule

// *** verification/operating_mode_power_control_tb.sv ***
// Self-checking testbench for the operating mode and power controller.
`timescale 1ns/10ps
module operating_mode_power_control_tb;
	import omp_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic hl = 1'b1, ien = 1'b0, keep = 1'b0, halt = 1'b0, wake = 1'b0, wto = 1'b0, wclr = 1'b0;
	logic [2:0] cds = 3'h0;
	logic [2:0] mode;
	logic ftick, stick, fen, rdy, sys, cpu, tbt, slw, d16, d64, hold, ret, wclo, power_down_flag, tof;
	logic [2:0] em [3] = '{OMP_SLEEP, OMP_IDLE_CLOCK_STOPPED_MODE, OMP_IDLE_CLOCK_RUNNING_MODE};
	int failures = 0;
	int cmp_count = 0;
	int ns, nc, nt, n16, n64, nl, n;
	omp_mode_ctrl #(.READY_TICKS(2)) i_omp_mode_ctrl (.clock_i(clock_i), .rst_i(rst_i),
		.hi_lo_clock_select_i(hl), .clock_divider_select_i(cds), .idle_on_halt_enable_i(ien),
		.keep_sysclk_in_idle_i(keep), .halt_exec_i(halt), .wake_i(wake), .wdt_timeout_i(wto),
		.wdt_clear_insn_i(wclr), .fast_osc_tick_i(ftick), .slow_osc_tick_i(stick), .mode_o(mode),
		.fast_osc_enable_o(fen), .fast_osc_ready_flag_o(rdy), .sys_clk_tick_o(sys), .cpu_clk_tick_o(cpu),
		.time_base_tick_o(tbt), .slow_clk_tick_o(slw), .fast_div16_tick_o(d16), .fast_div64_tick_o(d64),
		.cpu_hold_o(hold), .state_retain_o(ret), .watchdog_clear_o(wclo), .power_down_flag_o(power_down_flag),
		.watchdog_timeout_flag_o(tof));
	omp_osc_model i_omp_osc_model (.clock_i(clock_i), .rst_i(rst_i), .fast_enable_i(fen),
		.fast_tick_o(ftick), .slow_tick_o(stick));
	// Half period of 20 ns gives the 25 MHz clock.
	always #20 clock_i = ~clock_i;
	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Counts the tick outputs over a window, sampling after each edge has settled.
	task automatic win(input int len);
		ns = 0;
		nc = 0;
		nt = 0;
		n16 = 0;
		n64 = 0;
		nl = 0;
		repeat (len)
		begin
			@(posedge clock_i);
			#1;
			ns += (sys === 1'b1);
			nc += (cpu === 1'b1);
			nt += (tbt === 1'b1);
			n16 += (d16 === 1'b1);
			n64 += (d64 === 1'b1);
			nl += (slw === 1'b1);
		end
	endtask
	// Polls the ready flag the way software must before trusting the fast clock.
	task automatic wait_ready();
		int i;
		for (i = 0; i < 400 && rdy !== 1'b1; i++)
		begin
			@(posedge clock_i);
			#1;
		end
		check(rdy, 1'b1);
	endtask
	// One-cycle pulse on wake when w is set, on halt otherwise.
	task automatic pulse(input bit w);
		@(posedge clock_i);
		if (w)
			wake <= 1'b1;
		else
			halt <= 1'b1;
		@(posedge clock_i);
		wake <= 1'b0;
		halt <= 1'b0;
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Reset state, then a wake request in a run mode must be ignored.
	task automatic t_reset();
		check(mode, OMP_NORMAL);
		check({fen, power_down_flag, tof, hold}, 4'h8);
		wait_ready();
		pulse(1'b1);
		win(4);
		check(mode, OMP_NORMAL);
	endtask
	// Every divider code with the select bit low, slow for 0/1 and fast for the rest.
	task automatic t_slow();
		int c;
		for (c = 0; c < 8; c++)
		begin
			@(posedge clock_i);
			hl <= 1'b0;
			cds <= c[2:0];
			win(8);
			win(300);
			check(mode, (c < 2) ? OMP_SLOW : OMP_NORMAL);
			check(fen, c >= 2);
			check(n16 == 0, c < 2);
			check(n64 == 0, c < 2);
			check(nt > 0, 1'b1);
			check(nl > 0, 1'b1);
		end
	endtask
	// Fast ticks per system period for every ratio, undivided last.
	task automatic t_div();
		int c;
		int i;
		for (c = 2; c < 9; c++)
		begin
			@(posedge clock_i);
			hl <= (c == 8);
			cds <= c[2:0];
			win(300);
			for (i = 0; i < 200 && sys !== 1'b1; i++)
				win(1);
			n = 0;
			for (i = 0; i < 200; i++)
			begin
				@(posedge clock_i);
				#1;
				n += (ftick === 1'b1);
				if (sys === 1'b1)
					break;
			end
			check(n, (c == 8) ? 1 : (1 << (8 - c)));
		end
	endtask
	// Sleep, clock-stopped idle and clock-running idle, each entered and woken.
	task automatic t_halt();
		int k;
		for (k = 0; k < 3; k++)
		begin
			@(posedge clock_i);
			ien <= (k > 0);
			keep <= (k == 2);
			wto <= 1'b1;
			wclr <= 1'b1;
			@(posedge clock_i);
			wto <= 1'b0;
			wclr <= 1'b0;
			pulse(1'b0);
			check(mode, em[k]);
			check({wclo, power_down_flag, tof}, 3'h6);
			check({hold, ret}, 2'h3);
			pulse(1'b0);
			win(64);
			check(mode, em[k]);
			check({nc == 0, nt > 0, ns > 0}, {1'b1, k > 0, k == 2});
			check({rdy, fen}, {k == 2, k == 2});
			pulse(1'b1);
			win(1);
			check({mode, hold}, {OMP_NORMAL, 1'b0});
			wait_ready();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (failures == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// A hang counts as a mismatch; the budget is several times the expected run.
	initial
	begin
		#1600000;
		failures++;
		finish_test();
	end
	initial
	begin
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		#1;
		t_reset();
		t_slow();
		t_div();
		t_halt();
		finish_test();
	end
endmodule
